//--- core/param_dict_map.vh
`ifndef PARAM_DICT_MAP_VH
`define PARAM_DICT_MAP_VH

// Dictionary areas (upper index bits)
`define IDX_IDENTITY_BASE   16'h1000
`define IDX_LEGACY_BASE     16'h4000
`define IDX_INPUT_PDO_BASE  16'h6000
`define IDX_OUTPUT_PDO_BASE 16'h7000
`define IDX_CHANNEL_BASE    16'h8000
`define IDX_STORAGE_CTRL    16'hf008
`define IDX_WDG_MULT        16'hf100
`define IDX_WDG_TIME        16'hf101
`define IDX_WDG_ENABLE      16'hf102
`define IDX_WDG_STATUS      16'hf103
`define IDX_CHANNEL_STEP    16'h0010

// Channel geometry
`define NUM_CHANNELS        4
`define CH_SUBIDX_COUNT     8
`define CH_ENTRY_BITS       5

// Storage suppression code word
`define STORAGE_CODE_WORD   32'h12345678
`define STORAGE_CTRL_RESET  32'h00000000

// Identity values (arbitrary, neutral)
`define ID_DEVICE_NAME      32'h00000001
`define ID_MAKER_CODE       32'h00000002
`define ID_SERIAL_NUMBER    32'h00000003
`define ID_PDO_CONFIG       32'h00000004

// Watchdog timing: base period 40 ns, tick = (mult + 2) base periods
`define WDG_BASE_PERIOD_NS  40
`define CLK_PERIOD_NS       10
`define WDG_MULT_RESET      16'd2498
`define WDG_TIME_RESET      16'd1000
`define WDG_ENABLE_RESET    1'b1

// Answer codes
`define RESP_OK             2'd0
`define RESP_NO_ENTRY       2'd1
`define RESP_READ_ONLY      2'd2

`endif

//--- core/process_data_watchdog.v
`timescale 1ns/1ps
`default_nettype none
`include "param_dict_map.vh"

module process_data_watchdog (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire [15:0] mult_i,
    input  wire [15:0] time_i,
    input  wire        enable_i,
    input  wire        exchange_i,
    output reg         tripped_o
);
    localparam integer CLK_PER_BASE_I = `WDG_BASE_PERIOD_NS / `CLK_PERIOD_NS;
    localparam [7:0]   CLK_PER_BASE   = CLK_PER_BASE_I[7:0];

    reg [7:0]  base_cnt_q;
    reg [16:0] tick_cnt_q;
    reg [15:0] wdg_cnt_q;
    wire       base_pulse;
    wire       wdg_tick;
    wire       armed;

    assign base_pulse = (base_cnt_q == CLK_PER_BASE - 8'd1);
    assign wdg_tick   = base_pulse &&
                        (tick_cnt_q == {1'b0, mult_i} + 17'd1);
    assign armed      = enable_i && (time_i != 16'd0);

    always @(posedge clock_i) begin
        if (rst_i) begin
            base_cnt_q <= 8'h00;
            tick_cnt_q <= 17'h00000;
            wdg_cnt_q  <= 16'h0000;
            tripped_o  <= 1'b0;
        end else begin
            // Prescalers restart too, so the timeout is exact, not one tick short
            if (exchange_i) begin
                base_cnt_q <= 8'h00;
                tick_cnt_q <= 17'h00000;
            end else begin
                base_cnt_q <= base_pulse ? 8'h00 : base_cnt_q + 8'd1;
                if (wdg_tick)
                    tick_cnt_q <= 17'h00000;
                else if (base_pulse)
                    tick_cnt_q <= tick_cnt_q + 17'd1;
            end
            if (exchange_i || !armed) begin
                wdg_cnt_q <= 16'h0000;
                tripped_o <= 1'b0;
            end else if (wdg_tick && !tripped_o) begin
                if (wdg_cnt_q + 16'd1 >= time_i)
                    tripped_o <= 1'b1;
                else
                    wdg_cnt_q <= wdg_cnt_q + 16'd1;
            end
        end
    end
endmodule // process_data_watchdog

`default_nettype wire

//--- core/param_dictionary_with_watchdog.v
`timescale 1ns/1ps
`default_nettype none
`include "param_dict_map.vh"

module param_dictionary_with_watchdog (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        req_valid_i,
    input  wire        req_write_i,
    input  wire [15:0] req_index_i,
    input  wire [7:0]  req_subindex_i,
    input  wire [31:0] req_wdata_i,
    output reg         rsp_valid_o,
    output reg  [1:0]  rsp_code_o,
    output reg  [31:0] rsp_rdata_o,
    input  wire        pd_exchange_i,
    input  wire [31:0] pd_out_i,
    input  wire [31:0] pd_in_i,
    output reg  [31:0] outputs_o,
    output reg         wdg_tripped_o,
    output reg         storage_suppressed_o,
    output reg         nv_write_o,
    output reg  [15:0] nv_index_o,
    output reg  [7:0]  nv_subindex_o,
    output reg  [31:0] nv_data_o,
    input  wire        nv_done_i
);
    localparam ENTRIES = `NUM_CHANNELS * `CH_SUBIDX_COUNT;

    reg [31:0] chan_mem_q [0:ENTRIES-1];
    reg [31:0] storage_ctrl_q;
    reg [15:0] wdg_mult_q;
    reg [15:0] wdg_time_q;
    reg        wdg_enable_q;
    reg [31:0] pd_out_q;
    reg [31:0] pd_in_q;
    reg        nv_busy_q;
    reg        nv_done_s1_q;
    reg        nv_done_s2_q;
    wire       wdg_trip;
    integer    i;

    // Channel slot: returns {hit, entry}; both areas decode the same slot
    function [`CH_ENTRY_BITS:0] chan_slot;
        input [15:0] idx;
        input [7:0]  sub;
        reg   [15:0] off;
        begin
            off = idx - ((idx[15:12] == 4'h4) ? `IDX_LEGACY_BASE
                                              : `IDX_CHANNEL_BASE);
            chan_slot = {(off[15:4] < `NUM_CHANNELS) &&
                         (off[3:0] == 4'h0) &&
                         (sub < `CH_SUBIDX_COUNT),
                         off[5:4], sub[2:0]};
        end
    endfunction

    reg [`CH_ENTRY_BITS:0] slot;
    reg        hit;
    reg        ro;
    reg [31:0] rd;

    always @* begin
        slot = chan_slot(req_index_i, req_subindex_i);
        hit  = 1'b0;
        ro   = 1'b0;
        rd   = 32'h00000000;
        case (req_index_i[15:12])
            4'h1: begin
                if (req_index_i == `IDX_IDENTITY_BASE && req_subindex_i < 8'd4)
                begin
                    hit = 1'b1;
                    ro  = 1'b1;
                    case (req_subindex_i[1:0])
                        2'd0: rd = `ID_DEVICE_NAME;
                        2'd1: rd = `ID_MAKER_CODE;
                        2'd2: rd = `ID_SERIAL_NUMBER;
                        default: rd = `ID_PDO_CONFIG;
                    endcase
                end
            end
            4'h4, 4'h8: begin
                hit = slot[`CH_ENTRY_BITS];
                rd  = chan_mem_q[slot[`CH_ENTRY_BITS-1:0]];
            end
            4'h6: begin
                hit = (req_index_i == `IDX_INPUT_PDO_BASE) &&
                      (req_subindex_i == 8'h00);
                ro  = 1'b1;
                rd  = pd_in_q;
            end
            4'h7: begin
                hit = (req_index_i == `IDX_OUTPUT_PDO_BASE) &&
                      (req_subindex_i == 8'h00);
                ro  = 1'b1;
                rd  = pd_out_q;
            end
            4'hf: begin
                hit = (req_subindex_i == 8'h00);
                case (req_index_i)
                    `IDX_STORAGE_CTRL: rd = storage_ctrl_q;
                    `IDX_WDG_MULT:     rd = {16'h0000, wdg_mult_q};
                    `IDX_WDG_TIME:     rd = {16'h0000, wdg_time_q};
                    `IDX_WDG_ENABLE:   rd = {31'h00000000, wdg_enable_q};
                    `IDX_WDG_STATUS: begin
                        rd = {31'h00000000, wdg_tripped_o};
                        ro = 1'b1;
                    end
                    default: hit = 1'b0;
                endcase
            end
            default: hit = 1'b0;
        endcase
    end

    wire accept_wr = req_valid_i && req_write_i && hit && !ro;
    wire suppress  = (storage_ctrl_q == `STORAGE_CODE_WORD);
    wire persist   = accept_wr && !suppress &&
                     (req_index_i != `IDX_STORAGE_CTRL);

    always @(posedge clock_i) begin
        if (rst_i) begin
            rsp_valid_o          <= 1'b0;
            rsp_code_o           <= `RESP_OK;
            rsp_rdata_o          <= 32'h00000000;
            storage_ctrl_q       <= `STORAGE_CTRL_RESET;
            wdg_mult_q           <= `WDG_MULT_RESET;
            wdg_time_q           <= `WDG_TIME_RESET;
            wdg_enable_q         <= `WDG_ENABLE_RESET;
            pd_out_q             <= 32'h00000000;
            pd_in_q              <= 32'h00000000;
            outputs_o            <= 32'h00000000;
            wdg_tripped_o        <= 1'b0;
            storage_suppressed_o <= 1'b0;
            nv_write_o           <= 1'b0;
            nv_index_o           <= 16'h0000;
            nv_subindex_o        <= 8'h00;
            nv_data_o            <= 32'h00000000;
            nv_busy_q            <= 1'b0;
            nv_done_s1_q         <= 1'b0;
            nv_done_s2_q         <= 1'b0;
            for (i = 0; i < ENTRIES; i = i + 1)
                chan_mem_q[i] <= 32'h00000000;
        end else begin
            nv_done_s1_q <= nv_done_i;
            nv_done_s2_q <= nv_done_s1_q;
            rsp_valid_o  <= req_valid_i;
            rsp_rdata_o  <= (req_valid_i && hit && !req_write_i) ?
                            rd : 32'h00000000;
            if (!hit)
                rsp_code_o <= `RESP_NO_ENTRY;
            else if (req_write_i && ro)
                rsp_code_o <= `RESP_READ_ONLY;
            else
                rsp_code_o <= `RESP_OK;
            if (accept_wr) begin
                if (req_index_i[15:12] == 4'h4 ||
                    req_index_i[15:12] == 4'h8)
                    chan_mem_q[slot[`CH_ENTRY_BITS-1:0]] <=
                        req_wdata_i;
                case (req_index_i)
                    `IDX_STORAGE_CTRL: storage_ctrl_q <= req_wdata_i;
                    `IDX_WDG_MULT:     wdg_mult_q     <= req_wdata_i[15:0];
                    `IDX_WDG_TIME:     wdg_time_q     <= req_wdata_i[15:0];
                    `IDX_WDG_ENABLE:   wdg_enable_q   <= req_wdata_i[0];
                    default: ;
                endcase
            end
            storage_suppressed_o <= suppress;
            // Commit requests are held until the store acknowledges; a change written
            // while one is pending is dropped, so master should pace writes meanwhile
            if (persist && !nv_busy_q) begin
                nv_write_o    <= 1'b1;
                nv_busy_q     <= 1'b1;
                nv_index_o    <= req_index_i;
                nv_subindex_o <= req_subindex_i;
                nv_data_o     <= req_wdata_i;
            end else if (nv_busy_q && nv_done_s2_q) begin
                nv_write_o <= 1'b0;
                nv_busy_q  <= 1'b0;
            end
            if (pd_exchange_i) begin
                pd_out_q <= pd_out_i;
                pd_in_q  <= pd_in_i;
            end
            wdg_tripped_o <= wdg_trip;
            // Trip only zeroes the outputs; nothing else changes state
            outputs_o <= wdg_trip ? 32'h00000000 : pd_out_q;
        end
    end

    process_data_watchdog u_wdg (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .mult_i     (wdg_mult_q),
        .time_i     (wdg_time_q),
        .enable_i   (wdg_enable_q),
        .exchange_i (pd_exchange_i),
        .tripped_o  (wdg_trip)
    );
endmodule // param_dictionary_with_watchdog

`default_nettype wire

//--- verif/param_dict_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module param_dict_monitor (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        req_valid_i,
    input wire logic        req_write_i,
    input wire logic [15:0] req_index_i,
    input wire logic [7:0]  req_subindex_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic        pd_exchange_i,
    input wire logic        nv_done_i,
    input wire logic        rsp_valid_o,
    input wire logic [1:0]  rsp_code_o,
    input wire logic [31:0] outputs_o,
    input wire logic        wdg_tripped_o,
    input wire logic        storage_suppressed_o,
    input wire logic        nv_write_o,
    input wire logic [15:0] nv_index_o,
    input wire logic [7:0]  nv_subindex_o,
    input wire logic [31:0] nv_data_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_rsp_latency: assert property (
        rsp_valid_o == $past(req_valid_i)) else $error("answer timing wrong");
    a_ro_refused: assert property (
        req_valid_i && req_write_i && req_index_i == 16'h1000
        && req_subindex_i < 8'h04 |=> rsp_code_o == 2'h2)
        else $error("identity write not refused");
    a_unknown_err: assert property (
        req_valid_i && req_index_i == 16'h9000 |=> rsp_code_o == 2'h1)
        else $error("unknown entry not refused");
    a_trip_outputs: assert property (
        wdg_tripped_o |-> outputs_o == 32'h0) else $error("outputs live");
    a_trip_sticks: assert property (
        wdg_tripped_o && !pd_exchange_i && !$past(pd_exchange_i)
        |=> wdg_tripped_o) else $error("trip cleared without exchange");
    a_exch_restart: assert property (
        pd_exchange_i |-> ##2 !wdg_tripped_o) else $error("trip not cleared");
    a_nv_stable: assert property (
        nv_write_o && $past(nv_write_o)
        |-> $stable({nv_index_o, nv_subindex_o, nv_data_o}))
        else $error("commit data moved");
    a_nv_release: assert property (
        $rose(nv_done_i) |-> ##[1:5] !nv_write_o) else $error("commit hung");
    a_no_save_supp: assert property (
        storage_suppressed_o && !nv_write_o |=> !nv_write_o)
        else $error("commit while suppressed");
    a_code_word_on: assert property (
        req_valid_i && req_write_i && req_index_i == 16'hf008
        && req_subindex_i == 8'h00 && req_wdata_i == 32'h12345678
        |-> ##[1:2] storage_suppressed_o) else $error("no suppression");
    cover property ($rose(wdg_tripped_o));
    cover property ($rose(nv_write_o));
    cover property ($rose(storage_suppressed_o));
endmodule // param_dict_monitor
bind param_dictionary_with_watchdog param_dict_monitor param_dict_monitor_i (.*);
`default_nettype wire

//--- verif/nv_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
    input  wire logic       clock_i,
    input  wire logic       nv_write_i,
    input  wire logic [3:0] delay_i,
    output var  logic       nv_done_o
);
    logic [3:0] cnt_q = 4'h0;
    initial nv_done_o = 1'b0;
    // Done is held until the request drops, like a slow flash controller
    always @(posedge clock_i) begin
        if (nv_write_i !== 1'b1) begin
            cnt_q <= 4'h0;
            nv_done_o <= 1'b0;
        end else if (cnt_q == delay_i) begin
            nv_done_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // nv_store_model
`default_nettype wire

//--- verif/param_dictionary_with_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "param_dict_map.vh"
module param_dictionary_with_watchdog_tb;
    logic        clock_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
    logic        req_write_i = 1'b0, pd_exchange_i = 1'b0, nv_done_i;
    logic        rsp_valid_o, wdg_tripped_o, storage_suppressed_o;
    logic        nv_write_o, nv_prev = 1'b0;
    logic [15:0] req_index_i = 16'h0, nv_index_o;
    logic [7:0]  req_subindex_i = 8'h0, nv_subindex_o;
    logic [31:0] req_wdata_i = 32'h0, pd_out_i = 32'h0, pd_in_i = 32'h0;
    logic [31:0] rsp_rdata_o, outputs_o, nv_data_o, d;
    logic [1:0]  rsp_code_o;
    logic [3:0]  nv_delay = 4'h0;
    logic [33:0] rsp_q[$];
    logic [55:0] nv_q[$];
    logic [23:0] bad[6] = '{24'h800100, 24'h800008, 24'h100004,
                            24'h804000, 24'h900000, 24'h8030ff};
    int          errors = 0, cmp_count = 0, cyc = 0, n;
    always #5 clock_i = ~clock_i;
    param_dictionary_with_watchdog param_dictionary_with_watchdog_i (.*);
    nv_store_model nv_store_model_i (.clock_i(clock_i),
        .nv_write_i(nv_write_o), .delay_i(nv_delay), .nv_done_o(nv_done_i));
    task automatic cmp(input logic [55:0] g, input logic [55:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_rsp(input logic [33:0] e);
        cmp({22'h0, rsp_code_o, rsp_rdata_o}, {22'h0, e});
    endtask
    task automatic cmp_nv(input logic [55:0] e);
        cmp({nv_index_o, nv_subindex_o, nv_data_o}, e);
    endtask
    task automatic cmp_lvl(input logic [31:0] g, input logic [31:0] e);
        cmp({24'h0, g}, {24'h0, e});
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask
    task automatic req(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] wd, input logic [1:0] c,
                       input logic [31:0] r);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_index_i <= i;
        req_subindex_i <= s;
        req_wdata_i <= wd;
        rsp_q.push_back({c, r});
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        req_wdata_i <= ~wd;
    endtask
    task automatic commit(input logic [15:0] i, input logic [7:0] s,
                          input logic [31:0] wd);
        int k;
        nv_q.push_back({i, s, wd});
        nv_delay <= 4'($urandom_range(7));
        req(1'b1, i, s, wd, `RESP_OK, 32'h0);
        // The commit flag settles only after the edge that took the write
        tick(1);
        for (k = 0; k < 40 && nv_write_o !== 1'b0; k++) tick(1);
    endtask
    task automatic exch(input logic [31:0] v);
        @(posedge clock_i);
        pd_out_i <= v;
        pd_in_i <= ~v;
        pd_exchange_i <= 1'b1;
        @(posedge clock_i);
        pd_exchange_i <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Outputs are read before this edge's updates land, so no race
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        nv_prev <= nv_write_o;
        if (rsp_valid_o === 1'b1)
            cmp_rsp(rsp_q.size() ? rsp_q.pop_front() : 34'h3ffffffff);
        if (nv_write_o === 1'b1 && nv_prev !== 1'b1)
            cmp_nv(nv_q.size() ? nv_q.pop_front()
                   : ~{nv_index_o, nv_subindex_o, nv_data_o});
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'he9dbe34d));
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        req(0, `IDX_WDG_MULT, 0, 0, `RESP_OK, 32'h000009c2);
        req(0, `IDX_WDG_TIME, 0, 0, `RESP_OK, 32'h000003e8);
        req(0, `IDX_STORAGE_CTRL, 0, 0, `RESP_OK, 32'h0);
        for (n = 0; n < 4; n++) req(0, 16'h1000, n[7:0], 0, `RESP_OK, 32'(n + 1));
        req(1, 16'h1000, 0, 32'h5a, `RESP_READ_ONLY, 0);
        req(1, 16'h6000, 0, 32'h1, `RESP_READ_ONLY, 0);
        req(0, 16'h1000, 0, 0, `RESP_OK, `ID_DEVICE_NAME);
        foreach (bad[k]) req(k[0], bad[k][23:8], bad[k][7:0], 1, `RESP_NO_ENTRY, 0);
        for (n = 0; n < 4; n++) begin
            d = $urandom;
            commit(16'h8000 + 16'(n * 16), 8'(n * 2 + 1), d);
            req(0, 16'h4000 + 16'(n * 16), 8'(n * 2 + 1), 0, `RESP_OK, d);
        end
        req(1, `IDX_STORAGE_CTRL, 0, `STORAGE_CODE_WORD, `RESP_OK, 0);
        tick(2);
        cmp_lvl(storage_suppressed_o, 1);
        req(1, `IDX_WDG_MULT, 0, 0, `RESP_OK, 0);
        req(1, `IDX_WDG_TIME, 0, 1, `RESP_OK, 0);
        for (n = 0; n < 3; n++) begin
            d = $urandom;
            req(1, 16'h4020, 8'h01, d, `RESP_OK, 0);
            req(0, 16'h8020, 8'h01, 0, `RESP_OK, d);
        end
        for (n = 0; n < 4; n++) begin
            exch($urandom);
            tick(4);
        end
        cmp_lvl(wdg_tripped_o, 0);
        d = $urandom;
        exch(d);
        tick(3);
        cmp_lvl(outputs_o, d);
        tick(3);
        cmp_lvl(wdg_tripped_o, 0);
        tick(8);
        cmp_lvl({wdg_tripped_o, outputs_o[30:0]}, 32'h80000000);
        req(0, `IDX_WDG_STATUS, 0, 0, `RESP_OK, 1);
        req(0, 16'h6000, 0, 0, `RESP_OK, ~d);
        tick(20);
        cmp_lvl({wdg_tripped_o, storage_suppressed_o}, 3);
        exch(d);
        tick(3);
        cmp_lvl({wdg_tripped_o, outputs_o[30:0]}, {1'b0, d[30:0]});
        req(1, `IDX_WDG_TIME, 0, 0, `RESP_OK, 0);
        exch(d);
        tick(40);
        cmp_lvl(wdg_tripped_o, 0);
        req(1, `IDX_WDG_ENABLE, 0, 0, `RESP_OK, 0);
        req(1, `IDX_WDG_TIME, 0, 1, `RESP_OK, 0);
        exch(d);
        tick(40);
        cmp_lvl(wdg_tripped_o, 0);
        req(1, `IDX_STORAGE_CTRL, 0, 32'h12345679, `RESP_OK, 0);
        tick(2);
        cmp_lvl(storage_suppressed_o, 0);
        commit(16'h8030, 8'h07, $urandom);
        req(0, `IDX_STORAGE_CTRL, 0, 0, `RESP_OK, 32'h12345679);
        tick(3);
        cmp_lvl(32'(rsp_q.size() + nv_q.size()), 0);
        tally_and_finish();
    end
endmodule // param_dictionary_with_watchdog_tb
`default_nettype wire
